// ==== core/jbi_pkg.sv ====
// Shared constants, types and decode for the jump and field-insert unit.
// Assumes one core clock and 32-bit instruction words from the pipeline.
package jbi_pkg;

  ////////////////////////////////////////////////////////////////////
  // Opcode values.
  localparam logic [5:0] JBI_MAJ_POOL = 6'h00;
  localparam logic [5:0] JBI_MAJ_GOTO = 6'h35;
  localparam logic [5:0] JBI_MAJ_CALL = 6'h3d;
  localparam logic [5:0] JBI_FN_MERGE = 6'h0c;
  localparam logic [5:0] JBI_FN_AXF = 6'h3c;
  localparam logic [9:0] JBI_XF_RCALL = 10'h03c;

  ////////////////////////////////////////////////////////////////////
  // Field positions inside an instruction word, and the lowest region bit of an address.
  localparam int JBI_MAJ_LO = 26;
  localparam int JBI_TGT_LO = 21;
  localparam int JBI_SRC_LO = 16;
  localparam int JBI_TOP_LO = 11;
  localparam int JBI_BOT_LO = 6;
  localparam int JBI_XF_LO = 6;
  localparam int JBI_REGION_LSB = 27;

  ////////////////////////////////////////////////////////////////////
  // Link values, revision threshold and reset values.
  localparam logic [4:0] JBI_LINK_REG = 5'h1f;
  localparam logic [31:0] JBI_LINK_OFS = 32'h00000008;
  localparam int JBI_REV_MERGE = 2;
  localparam logic [31:0] JBI_RST_WORD = 32'h00000000;
  localparam logic [4:0] JBI_RST_IDX = 5'h00;
  localparam logic JBI_RST_ISA = 1'b0;

  // Instruction classes handled by the unit.
  typedef enum {
    JBI_K_NONE, JBI_K_MERGE, JBI_K_GOTO, JBI_K_CALL, JBI_K_RCALL
  } jbi_kind_t;

  // Classifies a 32-bit instruction word.
  function automatic jbi_kind_t jbi_decode(input logic [31:0] w);
    jbi_kind_t k;
    k = JBI_K_NONE;
    case (w[31:JBI_MAJ_LO])
      JBI_MAJ_GOTO: k = JBI_K_GOTO;
      JBI_MAJ_CALL: k = JBI_K_CALL;
      JBI_MAJ_POOL: begin
        if (w[5:0] == JBI_FN_MERGE) begin
          k = JBI_K_MERGE;
        end else if (w[5:0] == JBI_FN_AXF &&
                     w[15:JBI_XF_LO] == JBI_XF_RCALL) begin
          k = JBI_K_RCALL;
        end
      end
      default: k = JBI_K_NONE;
    endcase
    return k;
  endfunction

endpackage

// ==== core/jbi_if.sv ====
// Link between the pipeline end and the execution end of the unit.
// Assumes both ends share clk_in; no clocking is held here.
`timescale 1ns/1ns
interface jbi_if;
  // Issue group, driven by the pipeline end.
  logic issue_valid;
  logic [31:0] issue_instr;
  logic [31:0] issue_pc;
  logic issue_short;
  logic [31:0] src_val;
  logic [31:0] tgt_val;
  // Answer group, driven by the execution end.
  logic wb_valid;
  logic [4:0] wb_idx;
  logic [31:0] wb_data;
  logic redir_valid;
  logic [31:0] redir_pc;
  logic isa_sel;
  logic resv_exc;

  // Execution end.
  modport dev (
    input issue_valid, issue_instr, issue_pc, issue_short,
    input src_val, tgt_val,
    output wb_valid, wb_idx, wb_data, redir_valid, redir_pc,
    output isa_sel, resv_exc
  );

  // Pipeline end.
  modport host (
    output issue_valid, issue_instr, issue_pc, issue_short,
    output src_val, tgt_val,
    input wb_valid, wb_idx, wb_data, redir_valid, redir_pc,
    input isa_sel, resv_exc
  );
endinterface

// ==== core/jbi_exec_dev.sv ====
// Execution end: field merge, region jumps and register jumps.
// Assumes the pipeline end presents at most one instruction per cycle,
// with operands already read, and issues the delay slot after a jump.
`timescale 1ns/1ns
module jbi_exec_dev #(
  parameter int ARCH_REV = 2,
  parameter bit DUAL_ISA = 1'b1
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // Link to the pipeline end.
  jbi_if.dev lnk,
  // User side status.
  output logic slot_pending_out
);
  import jbi_pkg::*;

  typedef enum {JBI_S_IDLE, JBI_S_SLOT} jbi_dstate_t;

  ////////////////////////////////////////////////////////////////////
  // State.
  jbi_dstate_t state_reg;
  jbi_dstate_t state_next;
  logic [26:0] pend_low_reg;
  logic [26:0] pend_low_next;
  logic [31:0] pend_src_reg;
  logic [31:0] pend_src_next;
  logic pend_rj_reg;
  logic pend_rj_next;
  logic wb_valid_reg;
  logic wb_valid_next;
  logic [4:0] wb_idx_reg;
  logic [4:0] wb_idx_next;
  logic [31:0] wb_data_reg;
  logic [31:0] wb_data_next;
  logic redir_valid_reg;
  logic redir_valid_next;
  logic [31:0] redir_pc_reg;
  logic [31:0] redir_pc_next;
  logic isa_reg;
  logic isa_next;
  logic exc_reg;
  logic exc_next;
  logic slot_reg;
  logic slot_next;

  ////////////////////////////////////////////////////////////////////
  // Decoded fields of the issued word.
  jbi_kind_t kind;
  logic [4:0] top_bit;
  logic [4:0] bot_bit;
  logic [4:0] tgt_idx;
  logic [31:0] shifted;
  logic [31:0] field_mask;
  logic [31:0] merged;
  logic [31:0] link_addr;

  // Field limits sit in bits 15..11 and 10..6.
  assign top_bit = lnk.issue_instr[JBI_TOP_LO +: 5];
  assign bot_bit = lnk.issue_instr[JBI_BOT_LO +: 5];
  assign tgt_idx = lnk.issue_instr[JBI_TGT_LO +: 5];
  assign kind = jbi_decode(lnk.issue_instr);

  // The return link is the second instruction after the jump.
  assign link_addr = lnk.issue_pc + JBI_LINK_OFS;

  // The source is moved up to the field bottom before masking.
  assign shifted = lnk.src_val << bot_bit;

  // One mask bit per position, set inside bottom..top.
  for (genvar i = 0; i < 32; i++) begin : g_mask
    assign field_mask[i] = (5'(i) >= bot_bit) && (5'(i) <= top_bit);
  end

  // Bits outside the field keep their target value.
  assign merged = (lnk.tgt_val & ~field_mask) |
                  (shifted & field_mask);

  ////////////////////////////////////////////////////////////////////
  // Next-state logic for execution, link and redirect.
  always_comb begin
    state_next = state_reg;
    pend_low_next = pend_low_reg;
    pend_src_next = pend_src_reg;
    pend_rj_next = pend_rj_reg;
    wb_valid_next = 1'b0;
    wb_idx_next = wb_idx_reg;
    wb_data_next = wb_data_reg;
    redir_valid_next = 1'b0;
    redir_pc_next = redir_pc_reg;
    isa_next = isa_reg;
    exc_next = 1'b0;
    slot_next = slot_reg;
    if (lnk.issue_valid) begin
      // The word issued after a jump is its delay slot.
      if (state_reg == JBI_S_SLOT) begin
        // The redirect fires only once the slot is taken.
        redir_valid_next = 1'b1;
        state_next = JBI_S_IDLE;
        slot_next = 1'b0;
        if (pend_rj_reg) begin
          // Bit 0 never reaches the address.
          redir_pc_next = {pend_src_reg[31:1], 1'b0};
          if (DUAL_ISA) begin
            isa_next = pend_src_reg[0];
          end
        end else begin
          // Upper bits follow the slot address, so a jump in the
          // last word of a region lands in the next region.
          redir_pc_next = {lnk.issue_pc[31:JBI_REGION_LSB],
                           pend_low_reg};
        end
      end
      case (kind)
        JBI_K_MERGE: begin
          if (ARCH_REV < JBI_REV_MERGE) begin
            // Older revisions do not know this encoding.
            exc_next = 1'b1;
          end else begin
            wb_valid_next = 1'b1;
            wb_idx_next = tgt_idx;
            wb_data_next = merged;
          end
        end
        JBI_K_GOTO, JBI_K_CALL: begin
          if (state_reg == JBI_S_IDLE) begin
            // Index bits 25..0 shifted left by one.
            pend_low_next = {lnk.issue_instr[25:0], 1'b0};
            pend_rj_next = 1'b0;
            state_next = JBI_S_SLOT;
            slot_next = 1'b1;
            if (kind == JBI_K_CALL) begin
              wb_valid_next = 1'b1;
              wb_idx_next = JBI_LINK_REG;
              wb_data_next = link_addr;
            end
          end
        end
        JBI_K_RCALL: begin
          if (state_reg == JBI_S_IDLE) begin
            // The source is captured now, before the slot can alter it.
            pend_src_next = lnk.src_val;
            pend_rj_next = 1'b1;
            state_next = JBI_S_SLOT;
            slot_next = 1'b1;
            wb_valid_next = 1'b1;
            wb_idx_next = tgt_idx;
            wb_data_next = link_addr;
          end
        end
        default: begin
          wb_valid_next = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= JBI_S_IDLE;
      pend_low_reg <= JBI_RST_WORD[26:0];
      pend_src_reg <= JBI_RST_WORD;
      pend_rj_reg <= 1'b0;
      wb_valid_reg <= 1'b0;
      wb_idx_reg <= JBI_RST_IDX;
      wb_data_reg <= JBI_RST_WORD;
      redir_valid_reg <= 1'b0;
      redir_pc_reg <= JBI_RST_WORD;
      isa_reg <= JBI_RST_ISA;
      exc_reg <= 1'b0;
      slot_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pend_low_reg <= pend_low_next;
      pend_src_reg <= pend_src_next;
      pend_rj_reg <= pend_rj_next;
      wb_valid_reg <= wb_valid_next;
      wb_idx_reg <= wb_idx_next;
      wb_data_reg <= wb_data_next;
      redir_valid_reg <= redir_valid_next;
      redir_pc_reg <= redir_pc_next;
      isa_reg <= isa_next;
      exc_reg <= exc_next;
      slot_reg <= slot_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs come straight from the registers.
  assign lnk.wb_valid = wb_valid_reg;
  assign lnk.wb_idx = wb_idx_reg;
  assign lnk.wb_data = wb_data_reg;
  assign lnk.redir_valid = redir_valid_reg;
  assign lnk.redir_pc = redir_pc_reg;
  assign lnk.isa_sel = isa_reg;
  assign lnk.resv_exc = exc_reg;
  assign slot_pending_out = slot_reg;

endmodule

// ==== core/jbi_exec_host.sv ====
// Pipeline end: screens requests, issues them and returns the answers.
// Assumes the user side offers one request per cycle with operands read
// and flags any other branch, return or wait instruction itself.
`timescale 1ns/1ns
module jbi_exec_host (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic nrst_in,
  // User request.
  input wire logic req_valid_in,
  input wire logic [31:0] req_instr_in,
  input wire logic [31:0] req_pc_in,
  input wire logic req_short_in,
  input wire logic req_ctl_in,
  input wire logic [31:0] req_src_in,
  input wire logic [31:0] req_tgt_in,
  // User answers.
  output logic req_reject_out,
  output logic res_wb_valid_out,
  output logic [4:0] res_wb_idx_out,
  output logic [31:0] res_wb_data_out,
  output logic res_redir_valid_out,
  output logic [31:0] res_redir_pc_out,
  output logic res_isa_out,
  output logic res_exc_out,
  // Link to the execution end.
  jbi_if.host lnk
);
  import jbi_pkg::*;

  typedef enum {JBI_H_FREE, JBI_H_SLOT, JBI_H_SLOT_LONG} jbi_hstate_t;

  ////////////////////////////////////////////////////////////////////
  // State.
  jbi_hstate_t state_reg;
  jbi_hstate_t state_next;
  logic iss_valid_reg;
  logic iss_valid_next;
  logic [31:0] iss_instr_reg;
  logic [31:0] iss_pc_reg;
  logic iss_short_reg;
  logic [31:0] iss_src_reg;
  logic [31:0] iss_tgt_reg;
  logic reject_reg;
  logic reject_next;
  logic res_wb_valid_reg;
  logic [4:0] res_wb_idx_reg;
  logic [31:0] res_wb_data_reg;
  logic res_redir_valid_reg;
  logic [31:0] res_redir_pc_reg;
  logic res_isa_reg;
  logic res_exc_reg;
  jbi_kind_t kind;
  logic is_jump;
  logic viol;

  assign kind = jbi_decode(req_instr_in);
  assign is_jump = (kind == JBI_K_GOTO) || (kind == JBI_K_CALL) ||
                   (kind == JBI_K_RCALL);

  // Requests the execution end must never see are refused here.
  always_comb begin
    viol = 1'b0;
    if (kind == JBI_K_MERGE &&
        req_instr_in[JBI_BOT_LO +: 5] >
        req_instr_in[JBI_TOP_LO +: 5]) begin
      viol = 1'b1;
    end
    if (kind == JBI_K_RCALL &&
        req_instr_in[JBI_SRC_LO +: 5] ==
        req_instr_in[JBI_TGT_LO +: 5]) begin
      viol = 1'b1;
    end
    if (state_reg != JBI_H_FREE && (is_jump || req_ctl_in)) begin
      viol = 1'b1;
    end
    if (state_reg == JBI_H_SLOT_LONG && req_short_in) begin
      viol = 1'b1;
    end
  end

  // Issue and delay-slot tracking.
  always_comb begin
    state_next = state_reg;
    iss_valid_next = req_valid_in && !viol;
    reject_next = req_valid_in && viol;
    if (iss_valid_next) begin
      case (state_reg)
        JBI_H_FREE: begin
          if (kind == JBI_K_GOTO) begin
            state_next = JBI_H_SLOT;
          end else if (is_jump) begin
            state_next = JBI_H_SLOT_LONG;
          end
        end
        default: state_next = JBI_H_FREE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Registers; issue fields load only on an accepted request.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= JBI_H_FREE;
      iss_valid_reg <= 1'b0;
      iss_instr_reg <= JBI_RST_WORD;
      iss_pc_reg <= JBI_RST_WORD;
      iss_short_reg <= 1'b0;
      iss_src_reg <= JBI_RST_WORD;
      iss_tgt_reg <= JBI_RST_WORD;
      reject_reg <= 1'b0;
      res_wb_valid_reg <= 1'b0;
      res_wb_idx_reg <= JBI_RST_IDX;
      res_wb_data_reg <= JBI_RST_WORD;
      res_redir_valid_reg <= 1'b0;
      res_redir_pc_reg <= JBI_RST_WORD;
      res_isa_reg <= JBI_RST_ISA;
      res_exc_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      iss_valid_reg <= iss_valid_next;
      reject_reg <= reject_next;
      if (iss_valid_next) begin
        iss_instr_reg <= req_instr_in;
        iss_pc_reg <= req_pc_in;
        iss_short_reg <= req_short_in;
        iss_src_reg <= req_src_in;
        iss_tgt_reg <= req_tgt_in;
      end
      res_wb_valid_reg <= lnk.wb_valid;
      res_wb_idx_reg <= lnk.wb_idx;
      res_wb_data_reg <= lnk.wb_data;
      res_redir_valid_reg <= lnk.redir_valid;
      res_redir_pc_reg <= lnk.redir_pc;
      res_isa_reg <= lnk.isa_sel;
      res_exc_reg <= lnk.resv_exc;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs.
  assign lnk.issue_valid = iss_valid_reg;
  assign lnk.issue_instr = iss_instr_reg;
  assign lnk.issue_pc = iss_pc_reg;
  assign lnk.issue_short = iss_short_reg;
  assign lnk.src_val = iss_src_reg;
  assign lnk.tgt_val = iss_tgt_reg;
  assign req_reject_out = reject_reg;
  assign res_wb_valid_out = res_wb_valid_reg;
  assign res_wb_idx_out = res_wb_idx_reg;
  assign res_wb_data_out = res_wb_data_reg;
  assign res_redir_valid_out = res_redir_valid_reg;
  assign res_redir_pc_out = res_redir_pc_reg;
  assign res_isa_out = res_isa_reg;
  assign res_exc_out = res_exc_reg;

endmodule

// ==== tb/jbi_link_chk.sv ====
// Checker for the link that joins the pipeline end to the execution end.
// Assumes it sees the link signals, the core clock and the pipeline reset.
`timescale 1ns/1ns
module jbi_link_chk
  import jbi_pkg::*;
(
  // Clock, reset and link signals.
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [31:0] issue_pc,
  input wire logic issue_short,
  input wire logic [31:0] src_val,
  input wire logic [31:0] tgt_val,
  input wire logic wb_valid,
  input wire logic [4:0] wb_idx,
  input wire logic [31:0] wb_data,
  input wire logic redir_valid,
  input wire logic [31:0] redir_pc,
  input wire logic isa_sel,
  input wire logic resv_exc
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  ////////////////////////////////////////////////////////////////////
  logic [5:0] maj;
  logic mrg, rj, jmp, slot_reg, slot_next;
  logic [31:0] jw_reg, jw_next, js_reg, js_next, rgn;
  // Decode of the issued word and the region target it would give.
  assign maj = issue_instr[31:26];
  assign mrg = maj == JBI_MAJ_POOL && issue_instr[5:0] == JBI_FN_MERGE;
  assign rj = maj == JBI_MAJ_POOL && issue_instr[15:0] == 16'h0f3c;
  assign jmp = maj == JBI_MAJ_GOTO || maj == JBI_MAJ_CALL || rj;
  assign rgn = {issue_pc[31:27], jw_reg[25:0], 1'b0};

  // Remembers a jump until its delay slot has been issued.
  always_comb begin
    slot_next = slot_reg;
    jw_next = jw_reg;
    js_next = js_reg;
    if (issue_valid && slot_reg) begin
      slot_next = 1'b0;
    end else if (issue_valid && jmp) begin
      slot_next = 1'b1;
      jw_next = issue_instr;
      js_next = src_val;
    end
  end

  // Registers the slot tracking state.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slot_reg <= 1'b0;
      jw_reg <= 32'h00000000;
      js_reg <= 32'h00000000;
    end else begin
      slot_reg <= slot_next;
      jw_reg <= jw_next;
      js_reg <= js_next;
    end
  end

  // Expected field merge of a source into a target.
  function automatic logic [31:0] merge_f(input logic [31:0] w,
    input logic [31:0] s, input logic [31:0] t);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 32; i++) begin
      m[i] = i >= w[10:6] && i <= w[15:11];
    end
    return (t & ~m) | ((s << w[10:6]) & m);
  endfunction

  ////////////////////////////////////////////////////////////////////
  merge_result_a:
    assert property (issue_valid && mrg |=> wb_valid &&
      wb_idx == $past(issue_instr[25:21]) && wb_data ==
      merge_f($past(issue_instr), $past(src_val), $past(tgt_val)))
    else $error("merge write-back wrong");
  merge_no_exc_a:
    assert property (issue_valid && mrg |=> !resv_exc)
    else $error("reserved exception on merge");
  call_link_a:
    assert property (issue_valid && !slot_reg && maj == JBI_MAJ_CALL |=>
      wb_valid && wb_idx == JBI_LINK_REG &&
      wb_data == $past(issue_pc) + JBI_LINK_OFS)
    else $error("region call link wrong");
  rcall_link_a:
    assert property (issue_valid && !slot_reg && rj |=> wb_valid &&
      wb_idx == $past(issue_instr[25:21]) &&
      wb_data == $past(issue_pc) + JBI_LINK_OFS)
    else $error("register call link wrong");
  region_target_a:
    assert property (issue_valid && slot_reg && jw_reg[31:26] !=
      JBI_MAJ_POOL |=> redir_valid && redir_pc == $past(rgn))
    else $error("region target wrong");
  rcall_target_a:
    assert property (issue_valid && slot_reg && jw_reg[31:26] ==
      JBI_MAJ_POOL |=> redir_valid &&
      redir_pc == {js_reg[31:1], 1'b0} && isa_sel == js_reg[0])
    else $error("register target wrong");
  redir_after_slot_a:
    assert property (redir_valid |-> $past(issue_valid) && $past(slot_reg))
    else $error("redirect without delay slot");
  goto_no_early_a:
    assert property (issue_valid && !slot_reg && maj == JBI_MAJ_GOTO |=>
      !wb_valid && !redir_valid)
    else $error("goto answered before slot");
  call_slot_long_a:
    assert property (issue_valid && slot_reg && jw_reg[31:26] !=
      JBI_MAJ_GOTO |-> !issue_short)
    else $error("short delay slot after a call");
  slot_no_jump_a:
    assert property (issue_valid && slot_reg |-> !jmp)
    else $error("jump issued in a delay slot");
endmodule

// ==== tb/jump_and_bitfield_insert_exec_tb.sv ====
// Testbench joining both ends of the unit and driving the user side.
// Assumes the design files in core and the link checker are compiled.
`timescale 1ns/1ns
module jump_and_bitfield_insert_exec_tb;
  import jbi_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic rv = 1'b0, rsh = 1'b0, rct = 1'b0;
  logic [31:0] rw = 32'h00000000, rp = 32'h00000000;
  logic [31:0] src_d = 32'h00000000, tgt_d = 32'h00000000;
  logic rej, wbv, rdv, isa, exc, pend;
  logic [4:0] wbi, l_wbi;
  logic [31:0] wbd, rdp, l_wbd, l_rdp;
  logic l_isa;
  int error_cnt = 0, check_count = 0, cyc = 0;
  int n_wb = 0, n_rd = 0, n_rej = 0, n_exc = 0;

  ////////////////////////////////////////////////////////////////////
  jbi_if lnk();
  jbi_if lnk2();
  jbi_exec_host u_jbi_exec_host(.clk_in(clk_in), .nrst_in(nrst_in),
    .req_valid_in(rv), .req_instr_in(rw), .req_pc_in(rp),
    .req_short_in(rsh), .req_ctl_in(rct), .req_src_in(src_d),
    .req_tgt_in(tgt_d), .req_reject_out(rej), .res_wb_valid_out(wbv),
    .res_wb_idx_out(wbi), .res_wb_data_out(wbd), .res_redir_valid_out(rdv),
    .res_redir_pc_out(rdp), .res_isa_out(isa), .res_exc_out(exc),
    .lnk(lnk));
  jbi_exec_dev u_jbi_exec_dev(.clk_in(clk_in), .nrst_in(nrst_in),
    .lnk(lnk), .slot_pending_out(pend));
  // Older revision end, driven directly by the bench.
  jbi_exec_dev #(.ARCH_REV(1)) u_jbi_exec_dev_old(.clk_in(clk_in),
    .nrst_in(nrst_in), .lnk(lnk2), .slot_pending_out());
  jbi_link_chk u_jbi_link_chk(.clk_in(clk_in), .nrst_in(nrst_in),
    .issue_valid(lnk.issue_valid), .issue_instr(lnk.issue_instr),
    .issue_pc(lnk.issue_pc), .issue_short(lnk.issue_short),
    .src_val(lnk.src_val),
    .tgt_val(lnk.tgt_val), .wb_valid(lnk.wb_valid), .wb_idx(lnk.wb_idx),
    .wb_data(lnk.wb_data), .redir_valid(lnk.redir_valid),
    .redir_pc(lnk.redir_pc), .isa_sel(lnk.isa_sel),
    .resv_exc(lnk.resv_exc));

  // Clock at 4 ns and idle values on the directly driven link.
  initial begin
    lnk2.issue_valid = 1'b0;
    lnk2.issue_instr = 32'h00000000;
    lnk2.issue_pc = 32'h00000000;
    lnk2.issue_short = 1'b0;
    lnk2.src_val = 32'h00000000;
    lnk2.tgt_val = 32'h00000000;
    forever #2 clk_in = ~clk_in;
  end

  // Collects answers on the user side and cuts a hang short.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (rej === 1'b1) n_rej <= n_rej + 1;
    if (exc === 1'b1) n_exc <= n_exc + 1;
    if (wbv === 1'b1) begin
      n_wb <= n_wb + 1;
      l_wbi <= wbi;
      l_wbd <= wbd;
    end
    if (rdv === 1'b1) begin
      n_rd <= n_rd + 1;
      l_rdp <= rdp;
      l_isa <= isa;
    end
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Presents one request for one cycle.
  task automatic send(input logic [31:0] w, input logic [31:0] p,
    input logic sh, input logic ct, input logic [31:0] s);
    @(posedge clk_in);
    #1;
    rv = 1'b1;
    rw = w;
    rp = p;
    rsh = sh;
    rct = ct;
    src_d = s;
    tgt_d = 32'h5a5a5a5a;
    @(posedge clk_in);
    #1;
    rv = 1'b0;
  endtask

  // Lets answers arrive, then clears the collected counts.
  task automatic settle();
    repeat (5) @(posedge clk_in);
    #1;
  endtask
  task automatic clr();
    n_wb = 0;
    n_rd = 0;
    n_rej = 0;
    n_exc = 0;
  endtask

  // Field merges at the edges of the word and in bits 15..8, then a reversed field.
  task automatic t_merge();
    int tops[4] = '{0, 31, 31, 15};
    int bots[4] = '{0, 0, 31, 8};
    logic [31:0] m, w;
    for (int k = 0; k < 4; k++) begin
      m = 32'h00000000;
      for (int i = bots[k]; i <= tops[k]; i++) m[i] = 1'b1;
      w = {6'h00, 5'h09, 5'h0a, 5'(tops[k]), 5'(bots[k]), JBI_FN_MERGE};
      clr();
      send(w, 32'h00001000, 1'b0, 1'b0, 32'hcafef00d);
      settle();
      chk("merge count", 1, n_wb);
      chk("merge exc", 0, n_exc);
      chk("merge idx", 32'h00000009, 32'(l_wbi));
      chk("merge data", (32'h5a5a5a5a & ~m) |
        ((32'hcafef00d << bots[k]) & m), l_wbd);
    end
    clr();
    send({16'h0000, 5'h03, 5'h04, JBI_FN_MERGE}, 32'h0, 1'b0, 1'b0, 32'h1);
    settle();
    chk("reversed refused", 1, n_rej);
    chk("reversed wb", 0, n_wb);
  endtask

  // Region call in the last word of a region, with refused slots.
  task automatic t_call();
    clr();
    send({JBI_MAJ_CALL, 26'h1234567}, 32'h07fffffc, 1'b0, 1'b0, 32'h0);
    settle();
    chk("call link", 32'h08000004, l_wbd);
    chk("call idx", 32'h0000001f, 32'(l_wbi));
    chk("call early redir", 0, n_rd);
    chk("slot pending", 1, 32'(pend));
    send(32'hfc000000, 32'h08000000, 1'b1, 1'b0, 32'h0);
    send(32'hfc000000, 32'h08000000, 1'b0, 1'b1, 32'h0);
    send({JBI_MAJ_GOTO, 26'h0}, 32'h08000000, 1'b0, 1'b0, 32'h0);
    settle();
    chk("slot refusals", 3, n_rej);
    send(32'hfc000000, 32'h08000000, 1'b0, 1'b0, 32'h0);
    settle();
    chk("call redir", {5'h01, 26'h1234567, 1'b0}, l_rdp);
    chk("call wb count", 1, n_wb);
    chk("slot done", 0, 32'(pend));
  endtask

  // Region goto with a short slot straight after it.
  task automatic t_goto();
    clr();
    send({JBI_MAJ_GOTO, 26'h3ffffff}, 32'h10000000, 1'b0, 1'b0, 32'h0);
    send(32'hfc000000, 32'h10000004, 1'b1, 1'b0, 32'h0);
    settle();
    chk("goto refusals", 0, n_rej);
    chk("goto wb", 0, n_wb);
    chk("goto redir", {5'h02, 26'h3ffffff, 1'b0}, l_rdp);
  endtask

  // Register call with odd and even sources, then equal registers.
  task automatic t_rcall();
    logic [31:0] src[2] = '{32'h12345679, 32'h0abcdef0};
    for (int k = 0; k < 2; k++) begin
      clr();
      send({11'h005, 5'h07, 10'h03c, 6'h3c}, 32'h00400000, 1'b0, 1'b0,
        src[k]);
      send(32'hfc000000, 32'h00400004, 1'b0, 1'b0, 32'h0);
      settle();
      chk("rcall idx", 32'h00000005, 32'(l_wbi));
      chk("rcall link", 32'h00400008, l_wbd);
      chk("rcall target", src[k] & 32'hfffffffe, l_rdp);
      chk("rcall isa", 32'(src[k][0]), 32'(l_isa));
    end
    clr();
    send({11'h007, 5'h07, 10'h03c, 6'h3c}, 32'h0, 1'b0, 1'b0, 32'h0);
    settle();
    chk("rcall same regs", 1, n_rej);
  endtask

  // Older revision end must trap the merge instead of writing back.
  task automatic t_old();
    @(posedge clk_in);
    #1;
    lnk2.issue_valid = 1'b1;
    lnk2.issue_instr = {16'h0000, 5'h07, 5'h00, JBI_FN_MERGE};
    @(posedge clk_in);
    #1;
    lnk2.issue_valid = 1'b0;
    // The trap is a one-cycle pulse, so it is looked at while it stands.
    chk("old trap", 1, 32'(lnk2.resv_exc));
    chk("old wb", 0, 32'(lnk2.wb_valid));
  endtask

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Reset for 16 cycles, then every scenario in turn.
  initial begin
    repeat (16) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    t_merge();
    t_call();
    t_goto();
    t_rcall();
    t_old();
    complete_run();
  end
endmodule
